// ### logic/lvga_pkg.sv
/*
  Constants for the legacy VGA status register bank and its host end.
  Assumes both ends and the interface import this package whole.
*/
package lvga_pkg;

  // I/O byte addresses decoded by the device, and the offset to the second lane
  localparam logic [15:0] IO_ST0  = 16'h03C2;
  localparam logic [15:0] IO_GIDX = 16'h03CE;
  localparam logic [15:0] IO_GDAT = 16'h03CF;
  localparam logic [15:0] IO_NEXT = 16'h0001;

  // Extended graphics indexes behind the index/data pair
  localparam logic [7:0] GX_EXT_A = 8'h10;
  localparam logic [7:0] GX_EXT_B = 8'h11;
  localparam logic [7:0] GX_CTRL  = 8'h12;
  localparam logic [7:0] GX_STAT  = 8'h13;

  // Input status 0 layout and reset values
  localparam int unsigned ST0_IRQ   = 7;
  localparam int unsigned ST0_SENSE = 4;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;

  // Control index fields
  localparam int unsigned CTL_ARM  = 0;
  localparam int unsigned CTL_WO   = 1;
  localparam int unsigned CTL_WO_W = 3;

  // Status index fields
  localparam int unsigned STA_W1C  = 0;
  localparam int unsigned STA_W1S  = 1;
  localparam int unsigned STA_ARM  = 2;
  localparam int unsigned STA_WRS  = 3;
  localparam int unsigned STA_RETR = 4;
  localparam int unsigned STA_RW   = 5;
  localparam int unsigned STA_RW_W = 2;

  // Access sizes carried on the link
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD, SZ_RSVD} lvga_size_t;

  // Host command port map and fields
  localparam logic [1:0] HR_ADDR = 2'h0;
  localparam logic [1:0] HR_DATA = 2'h1;
  localparam logic [1:0] HR_CTRL = 2'h2;
  localparam logic [1:0] HR_STAT = 2'h3;
  localparam int unsigned HC_READ = 0;
  localparam int unsigned HC_SIZE = 1;
  localparam int unsigned HS_BUSY = 0;
  localparam int unsigned HS_ERR  = 1;

endpackage

// ### logic/lvga_if.sv
/*
  Legacy I/O cycle link between the host end and the register bank.
  Assumes both ends share sys_clk; one strobe per cycle at most.
*/
`timescale 1ns/100ps
interface lvga_if;
  import lvga_pkg::*;

  logic [15:0] io_addr;
  logic [15:0] io_wdata;
  lvga_size_t  io_size;
  logic        io_wr;
  logic        io_rd;
  logic [15:0] io_rdata;
  logic        io_rvalid;

  // Register bank end
  modport dev (input io_addr, io_wdata, io_size, io_wr, io_rd,
               output io_rdata, io_rvalid);
  // Host processor end
  modport host (output io_addr, io_wdata, io_size, io_wr, io_rd,
                input io_rdata, io_rvalid);
endinterface

// ### logic/lvga_dbuf.sv
/*
  Two-stage double-buffered byte register.
  Assumes load never coincides with a write; the parent guarantees it.
*/
`timescale 1ns/100ps
module lvga_dbuf
  import lvga_pkg::*;
#(
  parameter int W = 8
)(
  // Clock, reset, enable
  input  logic         sys_clk,
  input  logic         sys_rst,
  input  logic         ce,
  // Software side
  input  logic         wr_en,
  input  logic [W-1:0] wdata,
  // Update point
  input  logic         load,
  // Stage values
  output logic [W-1:0] stage1,
  output logic [W-1:0] stage2
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lvga_db_t;

  lvga_db_t st_r;
  lvga_db_t st_nxt;

  // Writes land in stage one, update copies it onward
  always_comb
  begin
    st_nxt = st_r;
    if (wr_en)
      st_nxt.s1 = wdata;                          // [RQ7]
    if (load)
      st_nxt.s2 = st_r.s1;                        // [RQ7] [RQ8]
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign stage1 = st_r.s1;
  assign stage2 = st_r.s2;
endmodule

// ### logic/lvga_dev.sv
/*
  Legacy VGA register bank: input status 0 plus extended graphics
  registers behind the index/data pair, covering every access type.
  Assumes the host keeps to byte or aligned word cycles on the link.
*/
// Notes on behaviour
// RQ1 - Read/write field stores, reads back, drives hardware
// RQ2 - Reserved bits ignore writes, read zero
// RQ3 - Read-only field reads hardware, writes ignored
// RQ4 - Write-only field drives hardware, reads zero
// RQ5 - Hardware sets sticky bit, write one clears
// RQ6 - Write one sets sticky bit, hardware clears
// RQ7 - Double buffer: stage one read, stage two drives
// RQ8 - Arming makes grouped registers load together
// RQ9 - Write to armed group disarms it
// RQ10 - Write stored for hardware, read shows status
// RQ11 - Software writes zero to must-be-zero fields
// RQ12 - Software writes back preserve-contents fields
// RQ13 - Only byte or aligned word cycles allowed
// RQ14 - Word cycles only at even addresses
// RQ15 - Host avoids doubleword cycles
// RQ16 - Extended registers use extra indexes only
// RQ17 - General registers decoded directly, no indexing
// RQ18 - Legacy mode only with other planes off
// RQ19 - Horizontal retrace spans porches and sync
// RQ20 - Input status 0 bit 7 reads zero
// RQ21 - Input status 0 bit 4 reads one
// RQ22 - Input status 0 read-only, no side effects
// RQ23 - Illegal size or alignment: ignored, reads zero
`timescale 1ns/100ps
module lvga_dev
  import lvga_pkg::*;
#(
  parameter int DW = 8
)(
  // Clock, reset, enable
  input  logic          sys_clk,
  input  logic          sys_rst,
  input  logic          ce,
  // Host link
  lvga_if.dev           io,
  // Hardware events and status
  input  logic          upd_pt,
  input  logic          hw_set_evt,
  input  logic          hw_clr_evt,
  input  logic          hw_stat,
  input  logic          hblank,
  input  logic          hsync,
  input  logic          planes_on,
  // Controls towards hardware
  output logic [DW-1:0] ext_a_live,
  output logic [DW-1:0] ext_b_live,
  output logic [CTL_WO_W-1:0] wo_ctrl,
  output logic          wrs_ctrl,
  output logic [STA_RW_W-1:0] rw_ctrl,
  output logic          grp_armed,
  output logic          w1c_flag,
  output logic          w1s_flag,
  output logic          vga_mode_en
);
  typedef struct packed {
    logic [7:0]          gidx;
    logic                armed;
    logic [CTL_WO_W-1:0] wo;
    logic                w1c;
    logic                w1s;
    logic                wrs;
    logic [STA_RW_W-1:0] rw;
    logic [15:0]         rdata;
    logic                rvalid;
    logic                vga_on;
  } lvga_dev_t;

  lvga_dev_t     st_r;
  lvga_dev_t     st_nxt;
  logic [1:0]    ext_wr;
  logic [DW-1:0] ext_wd;
  logic [DW-1:0] ext_s1 [2];
  logic [DW-1:0] ext_s2 [2];
  logic          load;
  logic          legal;
  logic [7:0]    st0_val;
  logic [7:0]    stat_val;

  // Only byte cycles or word cycles at even addresses are honoured
  assign legal = (io.io_size == SZ_BYTE) ||
                 ((io.io_size == SZ_WORD) && !io.io_addr[0]); // [RQ13] [RQ14]

  // Input status 0: sense high, pending and the rest zero
  always_comb
  begin
    st0_val = RST_BYTE;                           // [RQ22] [RQ2]
    st0_val[ST0_SENSE] = 1'b1;                    // [RQ21]
    st0_val[ST0_IRQ] = 1'b0;                      // [RQ20]
  end

  // Status index read image
  always_comb
  begin
    stat_val = RST_BYTE;                          // [RQ2]
    stat_val[STA_W1C] = st_r.w1c;                 // [RQ5]
    stat_val[STA_W1S] = st_r.w1s;                 // [RQ6]
    stat_val[STA_ARM] = st_r.armed;               // [RQ3]
    stat_val[STA_WRS] = hw_stat;                  // [RQ10]
    stat_val[STA_RETR] = hblank | hsync;          // [RQ19]
    stat_val[STA_RW +: STA_RW_W] = st_r.rw;       // [RQ1]
  end

  // Per-lane decode of reads and writes, then sticky and arming logic
  always_comb
  begin
    logic [15:0]         ba;
    logic [7:0]          wb;
    logic [7:0]          rb;
    logic [7:0]          wi;
    logic                lane_on;
    logic                arm_req;
    logic                clr_w1c;
    logic                set_w1s;
    logic [15:0]         rd;
    ba = RST_WORD;
    wb = RST_BYTE;
    rb = RST_BYTE;
    wi = st_r.gidx;
    lane_on = 1'b0;
    arm_req = 1'b0;
    clr_w1c = 1'b0;
    set_w1s = 1'b0;
    rd = RST_WORD;
    st_nxt = st_r;
    ext_wr = '0;
    ext_wd = '0;
    for (int ln = 0; ln < 2; ln++)
    begin
      ba = io.io_addr + (ln == 0 ? RST_WORD : IO_NEXT);
      wb = io.io_wdata[8*ln +: 8];
      lane_on = legal && (ln == 0 || io.io_size == SZ_WORD); // [RQ23]
      // Read path: no state changes on any read
      rb = RST_BYTE;
      case (ba)
        IO_ST0:  rb = st0_val;                    // [RQ17] [RQ22]
        IO_GIDX: rb = st_r.gidx;                  // [RQ17]
        IO_GDAT:
          case (st_r.gidx)
            GX_EXT_A: rb = ext_s1[0];             // [RQ7] [RQ16]
            GX_EXT_B: rb = ext_s1[1];             // [RQ7] [RQ16]
            GX_CTRL:  rb = RST_BYTE;              // [RQ4]
            GX_STAT:  rb = stat_val;
            default:  rb = RST_BYTE;
          endcase
        default: rb = RST_BYTE;
      endcase
      if (lane_on && io.io_rd)
        rd[8*ln +: 8] = rb;
      // Write path; index written by lane 0 steers lane 1
      if (lane_on && io.io_wr)
      begin
        case (ba)
          IO_GIDX: wi = wb;
          IO_GDAT:
            case (wi)
              GX_EXT_A:
              begin
                ext_wr[0] = 1'b1;                 // [RQ7] [RQ16]
                ext_wd = wb;
              end
              GX_EXT_B:
              begin
                ext_wr[1] = 1'b1;                 // [RQ7] [RQ16]
                ext_wd = wb;
              end
              GX_CTRL:
              begin
                arm_req = wb[CTL_ARM];            // [RQ8]
                st_nxt.wo = wb[CTL_WO +: CTL_WO_W]; // [RQ4]
              end
              GX_STAT:
              begin
                clr_w1c = wb[STA_W1C];            // [RQ5]
                set_w1s = wb[STA_W1S];            // [RQ6]
                st_nxt.wrs = wb[STA_WRS];         // [RQ10]
                st_nxt.rw = wb[STA_RW +: STA_RW_W]; // [RQ1]
              end
              default: ;                          // [RQ2]
            endcase
          default: ;                              // [RQ3] [RQ22]
        endcase
      end
    end
    st_nxt.gidx = wi;
    // Hardware set beats software clear
    st_nxt.w1c = (st_r.w1c & ~clr_w1c) | hw_set_evt;  // [RQ5]
    // Software set beats hardware clear
    st_nxt.w1s = (st_r.w1s & ~hw_clr_evt) | set_w1s;  // [RQ6]
    // Group write while armed disarms; update point consumes the arm
    st_nxt.armed = arm_req |
                   (st_r.armed & ~(|ext_wr) & ~upd_pt); // [RQ8] [RQ9]
    st_nxt.rdata = rd;                            // [RQ23]
    st_nxt.rvalid = io.io_rd;
    st_nxt.vga_on = st_r.rw[0] & ~planes_on;      // [RQ18]
  end

  // Grouped update only when armed and untouched this cycle
  assign load = upd_pt & st_r.armed & ~(|ext_wr); // [RQ8] [RQ9]

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  // One double buffer per extended register
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ext
      lvga_dbuf #(
        .W      (DW)
      ) u_dbuf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ce     (ce),
        .wr_en  (ext_wr[gi]),
        .wdata  (ext_wd),
        .load   (load),
        .stage1 (ext_s1[gi]),
        .stage2 (ext_s2[gi])
      );
    end
  endgenerate

  // Outputs straight from flip-flops
  assign io.io_rdata  = st_r.rdata;
  assign io.io_rvalid = st_r.rvalid;
  assign ext_a_live   = ext_s2[0];                // [RQ7]
  assign ext_b_live   = ext_s2[1];                // [RQ7]
  assign wo_ctrl      = st_r.wo;                  // [RQ4]
  assign wrs_ctrl     = st_r.wrs;                 // [RQ10]
  assign rw_ctrl      = st_r.rw;                  // [RQ1]
  assign grp_armed    = st_r.armed;
  assign w1c_flag     = st_r.w1c;
  assign w1s_flag     = st_r.w1s;
  assign vga_mode_en  = st_r.vga_on;              // [RQ18]
endmodule

// ### logic/lvga_host.sv
/*
  Host end: turns command-port orders into legacy I/O cycles.
  Assumes the register bank answers a read exactly one cycle later.
*/
`timescale 1ns/100ps
module lvga_host
  import lvga_pkg::*;
(
  // Clock, reset, enable
  input  logic        sys_clk,
  input  logic        sys_rst,
  input  logic        ce,
  // Command port
  input  logic [1:0]  usr_addr,
  input  logic [15:0] usr_wdata,
  input  logic        usr_wr,
  input  logic        usr_rd,
  output logic [15:0] usr_rdata,
  // Link to the bank
  lvga_if.host        io
);
  typedef enum logic {H_IDLE, H_WAIT} lvga_hst_t;

  typedef struct packed {
    lvga_hst_t   fsm;
    logic [15:0] addr;
    logic [15:0] data;
    lvga_size_t  size;
    logic        err;
    logic        io_wr;
    logic        io_rd;
    logic [15:0] urdata;
  } lvga_host_t;

  lvga_host_t st_r;
  lvga_host_t st_nxt;

  // Command decode, cycle issue and read capture
  always_comb
  begin
    logic       busy;
    lvga_size_t sz;
    logic       ok;
    logic       clr_err;
    logic       set_err;
    busy = (st_r.fsm != H_IDLE) | st_r.io_wr | st_r.io_rd;
    sz = lvga_size_t'(usr_wdata[HC_SIZE +: 2]);
    ok = (sz == SZ_BYTE) ||
         ((sz == SZ_WORD) && !st_r.addr[0]);      // [RQ13] [RQ14] [RQ15]
    clr_err = 1'b0;
    set_err = 1'b0;
    st_nxt = st_r;
    st_nxt.io_wr = 1'b0;
    st_nxt.io_rd = 1'b0;
    if (usr_wr && !busy)
    begin
      case (usr_addr)
        HR_ADDR: st_nxt.addr = usr_wdata;
        HR_DATA: st_nxt.data = usr_wdata;         // [RQ11] [RQ12]
        HR_CTRL:
          if (ok)
          begin
            st_nxt.size = sz;
            st_nxt.io_rd = usr_wdata[HC_READ];
            st_nxt.io_wr = ~usr_wdata[HC_READ];
            st_nxt.fsm = usr_wdata[HC_READ] ? H_WAIT : H_IDLE;
          end
          else
            set_err = 1'b1;                       // [RQ13] [RQ15]
        HR_STAT: clr_err = usr_wdata[HS_ERR];
        default: ;
      endcase
    end
    else if (usr_wr && usr_addr == HR_STAT)
      clr_err = usr_wdata[HS_ERR];
    // Refusal flag: new refusal beats clear
    st_nxt.err = (st_r.err & ~clr_err) | set_err;
    // Read answer arrives one cycle after the strobe
    case (st_r.fsm)
      H_IDLE: ;
      H_WAIT:
        if (io.io_rvalid)
        begin
          st_nxt.data = io.io_rdata;
          st_nxt.fsm = H_IDLE;
        end
      default: st_nxt.fsm = H_IDLE;
    endcase
    // Command port read data, one cycle later
    st_nxt.urdata = RST_WORD;
    if (usr_rd)
      case (usr_addr)
        HR_ADDR: st_nxt.urdata = st_r.addr;
        HR_DATA: st_nxt.urdata = st_r.data;
        HR_CTRL: st_nxt.urdata[HC_SIZE +: 2] = st_r.size;
        HR_STAT:
        begin
          st_nxt.urdata[HS_BUSY] = busy;
          st_nxt.urdata[HS_ERR] = st_r.err;
        end
        default: st_nxt.urdata = RST_WORD;
      endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  // Outputs straight from flip-flops
  assign usr_rdata   = st_r.urdata;
  assign io.io_addr  = st_r.addr;
  assign io.io_wdata = st_r.data;
  assign io.io_size  = st_r.size;
  assign io.io_wr    = st_r.io_wr;
  assign io.io_rd    = st_r.io_rd;
endmodule

// ### test/lvga_monitor.sv
/*
  Link checker for the legacy I/O cycles between host end and bank.
  Assumes ce stays high and it sits beside the one link of the bench.
*/
`timescale 1ns/100ps
module lvga_monitor
  import lvga_pkg::*;
(
  // Clock and reset
  input logic        sys_clk,
  input logic        sys_rst,
  // Link signals
  input logic [15:0] io_addr,
  input logic [15:0] io_wdata,
  input lvga_size_t  io_size,
  input logic        io_wr,
  input logic        io_rd,
  input logic [15:0] io_rdata,
  input logic        io_rvalid
);
  logic [7:0] idx_r;
  logic [7:0] exta_r;
  logic       rdb;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // Byte read strobe
  assign rdb = io_rd && io_size == SZ_BYTE;

  // Shadow of the index and of stage one of ext A
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      idx_r  <= 8'h00;
      exta_r <= 8'h00;
    end
    else if (io_wr && io_addr == IO_GIDX)
      idx_r <= io_wdata[7:0];
    else if (io_wr && io_addr == IO_GDAT && idx_r == GX_EXT_A)
      exta_r <= io_wdata[7:0];

  AST_RD_ANSWER:
    assert property (io_rd |=> io_rvalid)
    else $error("read not answered next cycle");
  AST_NO_STRAY:
    assert property (io_rvalid |-> $past(io_rd))
    else $error("answer without read");
  AST_IDLE_ZERO:
    assert property (!io_rvalid |-> io_rdata == 16'h0000)
    else $error("read data outside answer");
  AST_ONE_STROBE:
    assert property (!(io_wr && io_rd))
    else $error("both strobes high");
  AST_LEGAL_SIZE:
    assert property ((io_wr || io_rd) |-> io_size inside {SZ_BYTE, SZ_WORD})
    else $error("illegal cycle size");
  AST_WORD_EVEN:
    assert property ((io_wr || io_rd) && io_size == SZ_WORD |-> !io_addr[0])
    else $error("word cycle at odd address");
  AST_ST0_VALUE:
    assert property (rdb && io_addr == IO_ST0 |=> io_rdata[7:0] == 8'h10)
    else $error("status zero value wrong");
  AST_INDEX_BACK:
    assert property (rdb && io_addr == IO_GIDX
                     |=> io_rdata[7:0] == $past(idx_r))
    else $error("index readback wrong");
  AST_WO_ZERO:
    assert property (rdb && io_addr == IO_GDAT && idx_r == GX_CTRL
                     |=> io_rdata[7:0] == 8'h00)
    else $error("write-only index not zero");
  AST_RSVD_BIT:
    assert property (rdb && io_addr == IO_GDAT && idx_r == GX_STAT
                     |=> !io_rdata[7])
    else $error("reserved status bit set");
  AST_STAGE1_BACK:
    assert property (rdb && io_addr == IO_GDAT && idx_r == GX_EXT_A
                     |=> io_rdata[7:0] == $past(exta_r))
    else $error("stage one readback wrong");
endmodule

// ### test/legacy_vga_status_register_bank_bench.sv
/*
  Bench: host end and register bank joined by the link, driven through
  the host command port. Assumes package, link and both ends compile first.
*/
`timescale 1ns/100ps
module legacy_vga_status_register_bank_bench
  import lvga_pkg::*;
;
  // Clock, reset and command port
  logic        sys_clk, sys_rst, ce, usr_wr, usr_rd;
  logic [1:0]  usr_addr, rw_ctrl;
  logic [15:0] usr_wdata, usr_rdata, rd, st;
  // Bank hardware side
  logic [2:0]  ev, wo_ctrl;
  logic        hw_stat, hblank, hsync, planes_on, vga_mode_en;
  logic [7:0]  ext_a_live, ext_b_live;
  logic        wrs_ctrl, grp_armed, w1c_flag, w1s_flag;
  int          fails, num_checks;

  lvga_if io_l ();

  // Host end and bank facing each other, checker on the link
  lvga_host i_lvga_host (.sys_clk, .sys_rst, .ce, .usr_addr, .usr_wdata,
    .usr_wr, .usr_rd, .usr_rdata, .io(io_l.host));
  lvga_dev i_lvga_dev (.sys_clk, .sys_rst, .ce, .io(io_l.dev),
    .upd_pt(ev[0]), .hw_set_evt(ev[1]), .hw_clr_evt(ev[2]), .hw_stat,
    .hblank, .hsync, .planes_on, .ext_a_live, .ext_b_live, .wo_ctrl,
    .wrs_ctrl, .rw_ctrl, .grp_armed, .w1c_flag, .w1s_flag, .vga_mode_en);
  lvga_monitor i_lvga_monitor (.sys_clk, .sys_rst, .io_addr(io_l.io_addr),
    .io_wdata(io_l.io_wdata), .io_size(io_l.io_size), .io_wr(io_l.io_wr),
    .io_rd(io_l.io_rd), .io_rdata(io_l.io_rdata),
    .io_rvalid(io_l.io_rvalid));

  // 125 MHz clock
  initial
  begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Compare and count
  task automatic chk(input logic [15:0] g, e, input string m);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic endt(input string n);
    $display("test %s done, mismatches %0d", n, fails);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Command port write and read
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    usr_addr  <= a;
    usr_wdata <= d;
    usr_wr    <= 1'h1;
    @(posedge sys_clk);
    usr_wr <= 1'h0;
  endtask

  task automatic rdr(input logic [1:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    usr_addr <= a;
    usr_rd   <= 1'h1;
    @(posedge sys_clk);
    usr_rd <= 1'h0;
    #1 d = usr_rdata;
  endtask

  // One link cycle: ctl bit0 read, bits2:1 size; status left in st
  task automatic op(input logic [15:0] a, d, input logic [2:0] c);
    wr(HR_ADDR, a);
    wr(HR_DATA, d);
    wr(HR_CTRL, {13'h0000, c});
    for (int i = 0; i < 20; i++)
    begin
      rdr(HR_STAT, st);
      if (st[HS_BUSY] === 1'h0)
        break;
    end
    // Poll limit ran out: the cycle hung, count it
    chk(st[HS_BUSY], 16'h0, "busy");
  endtask

  task automatic bw(input logic [15:0] a, input logic [7:0] d);
    op(a, {8'h00, d}, 3'h0);
  endtask

  task automatic brd(input logic [15:0] a, input logic [7:0] e, string m);
    op(a, 16'h0000, 3'h1);
    rdr(HR_DATA, rd);
    chk(rd[7:0], e, m);
  endtask

  // Indexed write and read
  task automatic gw(input logic [7:0] i, d);
    bw(IO_GIDX, i);
    bw(IO_GDAT, d);
  endtask

  task automatic gr(input logic [7:0] i, e, input string m);
    bw(IO_GIDX, i);
    brd(IO_GDAT, e, m);
  endtask

  // Hardware event pulse and status levels
  task automatic pl(input int k);
    @(posedge sys_clk);
    ev[k] <= 1'h1;
    @(posedge sys_clk);
    ev[k] <= 1'h0;
    #1;
  endtask

  task automatic hw(input logic [3:0] v);
    @(posedge sys_clk);
    {hw_stat, hsync, hblank, planes_on} <= v;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    test_done;
  end

  // Main sequence
  initial
  begin
    sys_rst = 1'h1;
    ce = 1'h1;
    usr_addr = 2'h0;
    usr_wdata = 16'h0000;
    usr_wr = 1'h0;
    usr_rd = 1'h0;
    ev = 3'h0;
    {hw_stat, hsync, hblank, planes_on} = 4'h0;
    fails = 0;
    num_checks = 0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'h0;
    #1;
    chk({ext_a_live, ext_b_live}, 16'h0, "live reset");
    chk({wo_ctrl, rw_ctrl, w1c_flag, w1s_flag}, 16'h0, "ctl");
    brd(IO_ST0, 8'h10, "st0");
    bw(IO_ST0, 8'hFF);
    brd(IO_ST0, 8'h10, "st0 ro");
    endt("status0");
    gw(GX_STAT, 8'hE8);
    chk({rw_ctrl, wrs_ctrl}, 16'h7, "rw wrs");
    gr(GX_STAT, 8'h60, "stat");
    hw(4'hC);
    gr(GX_STAT, 8'h78, "stat hw");
    hw(4'h2);
    gr(GX_STAT, 8'h70, "stat blank");
    chk(vga_mode_en, 16'h1, "vga on");
    hw(4'h1);
    chk(vga_mode_en, 16'h0, "vga off");
    endt("fields");
    pl(1);
    gr(GX_STAT, 8'h61, "w1c set");
    gw(GX_STAT, 8'h60);
    chk(w1c_flag, 16'h1, "w1c zero");
    gw(GX_STAT, 8'h63);
    chk({w1c_flag, w1s_flag}, 16'h1, "w1c clr w1s set");
    pl(2);
    chk(w1s_flag, 16'h0, "w1s hw clr");
    gw(GX_CTRL, 8'h0E);
    chk(wo_ctrl, 16'h7, "wo");
    gr(GX_CTRL, 8'h00, "wo read");
    endt("sticky");
    gw(GX_EXT_A, 8'hA5);
    brd(IO_GIDX, GX_EXT_A, "index");
    gw(GX_EXT_B, 8'h5A);
    gr(GX_EXT_A, 8'hA5, "stage one");
    pl(0);
    chk({ext_a_live, ext_b_live}, 16'h0, "unarmed");
    gw(GX_CTRL, 8'h01);
    gr(GX_STAT, 8'h64, "armed");
    pl(0);
    chk({ext_a_live, ext_b_live}, 16'hA55A, "load");
    gw(GX_CTRL, 8'h01);
    gw(GX_EXT_A, 8'h77);
    chk(grp_armed, 16'h0, "disarm");
    pl(0);
    chk(ext_a_live, 16'hA5, "no load");
    gw(GX_CTRL, 8'h01);
    pl(0);
    chk(ext_a_live, 16'h77, "rearmed");
    endt("double buffer");
    op(IO_GIDX, 16'hC311, 3'h2);
    op(IO_GIDX, 16'h0000, 3'h3);
    rdr(HR_DATA, rd);
    chk(rd, 16'hC311, "word");
    op(IO_GDAT, 16'hFFFF, 3'h2);
    chk(st[HS_ERR], 16'h1, "odd word");
    wr(HR_STAT, 16'h0002);
    rdr(HR_STAT, st);
    chk(st[HS_ERR], 16'h0, "err clear");
    op(IO_GIDX, 16'hFFFF, 3'h4);
    chk(st[HS_ERR], 16'h1, "dword");
    wr(HR_STAT, 16'h0002);
    gr(GX_EXT_B, 8'hC3, "refused");
    endt("sizes");
    // Enable low freezes the sticky flag against a hardware event
    @(posedge sys_clk);
    ce <= 1'h0;
    pl(1);
    chk(w1c_flag, 16'h0, "frozen");
    @(posedge sys_clk);
    ce <= 1'h1;
    pl(1);
    chk(w1c_flag, 16'h1, "thawed");
    endt("freeze");
    test_done;
  end
endmodule
